// ---- common/charge_time_pkg.sv ----
// Register map, field positions and constants of the charge-time unit
package charge_time_pkg;
	// Byte addresses of the registers
	localparam logic [7:0] ADDR_CTRL_HIGH = 8'h00;
	localparam logic [7:0] ADDR_CTRL_LOW  = 8'h04;
	localparam logic [7:0] ADDR_CURRENT   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLR   = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;
	// control_high_reg fields
	localparam int MODULE_ENABLE_BIT = 7;
	localparam int IDLE_STOP_BIT     = 5;
	localparam int DELAY_GEN_BIT     = 4;
	localparam int EDGE_ENABLE_BIT   = 3;
	localparam int EDGE_SEQ_BIT      = 2;
	localparam int SOURCE_GROUND_BIT = 1;
	localparam int TRIGGER_BIT       = 0;
	localparam logic [7:0] CTRL_HIGH_MASK = 8'hBF;
	// control_low_reg fields
	localparam int EDGE_TWO_STAT_BIT = 1;
	localparam int EDGE_ONE_STAT_BIT = 0;
	// Current register range field, 00 means source off
	localparam int RANGE_LSB = 0;
	localparam logic [1:0] RANGE_OFF = 2'h0;
	// Interrupt events
	localparam int IRQ_PULSE_DONE = 0;
	localparam int IRQ_ABORTED    = 1;
	localparam int IRQ_WIDTH      = 2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {GEN_IDLE, GEN_CHARGE, GEN_PULSE} gen_state_e;
endpackage

// ---- rtl/charge_time_unit.sv ----
// Digital control of the charge-time measurement unit with APB registers
// How it works
// RL1: Absolute capacitance: software sets edge one, waits, clears it, then converts.
// RL2: Source charges the node while edge one set and edge two clear.
// RL3: Relative sensing needs no calibration; lower voltage means larger capacitance.
// RL4: Time measurement: edge one starts charging, edge two stops it.
// RL5: Delay generation runs only when its enable bit is set, output on pulse pin.
// RL6: In delay mode, charge the pulse capacitor until comparator two trips, then pulse.
// RL7: Software sets up comparator, reference, unit, then edge one, in that order.
// RL8: Pulse width comes from the capacitor charge, not the system clock; here the charge sets only the pulse start, edge-one clear ends it.
// RL9: Any Sleep mode disables the current source unconditionally.
// RL10: An operation cut by Sleep is not completed; its result flagged invalid.
// RL11: Stop-in-idle is bit 5 of control high; cleared keeps unit running in Idle.
// RL12: Stop-in-idle set: Idle disables source, operation treated as Sleep-aborted.
// RL13: Shortest times: software selects an unconnected converter channel.
// RL14: Unit operates only while the module enable bit is set.
// RL15: Source ground bit connects the source output to ground.
// RL16: Reset clears all unit registers; unit disabled, source off.
//
// Chosen here: register access over APB and the placing of the registers.
module charge_time_unit (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_req,
	input  wire logic        idle_req,
	input  wire logic        comparator_two_out,
	output logic             source_connect,
	output logic             source_ground,
	output logic [7:0]       current_setting,
	output logic             pulse_output_pin,
	output logic             adc_trigger,
	output logic             irq
);
	logic [7:0] control_high_reg;
	logic [7:0] control_low_reg;
	logic [7:0] current_reg;
	logic [charge_time_pkg::IRQ_WIDTH-1:0] irq_stat;
	logic [charge_time_pkg::IRQ_WIDTH-1:0] irq_en;
	logic [1:0] sleep_sync;
	logic [1:0] idle_sync;
	logic [1:0] cmp_sync;
	logic       cmp_q;
	logic       result_invalid;
	charge_time_pkg::gen_state_e gen_state;

	wire logic wr = psel && penable && pwrite;
	wire logic enabled = control_high_reg[charge_time_pkg::MODULE_ENABLE_BIT];
	wire logic delay_mode = control_high_reg[charge_time_pkg::DELAY_GEN_BIT];
	wire logic edge_one = control_low_reg[charge_time_pkg::EDGE_ONE_STAT_BIT];
	wire logic edge_two = control_low_reg[charge_time_pkg::EDGE_TWO_STAT_BIT];
	// Idle only stops the source when stop-in-idle is set
	wire logic halted = sleep_sync[1] || // RL9
		(idle_sync[1] && control_high_reg[charge_time_pkg::IDLE_STOP_BIT]); // RL11 RL12
	wire logic source_off =
		current_reg[charge_time_pkg::RANGE_LSB +: 2] == charge_time_pkg::RANGE_OFF;
	wire logic next_connect =
		enabled && !halted && !source_off && edge_one && !edge_two; // RL2 RL4 RL14
	wire logic cmp_rise = cmp_sync[1] && !cmp_q;
	wire logic [charge_time_pkg::IRQ_WIDTH-1:0] next_events;
	wire logic abort_event = halted && source_connect; // RL10 RL12

	// Pin inputs pass two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_sync <= 2'h0;
			idle_sync  <= 2'h0;
			cmp_sync   <= 2'h0;
			cmp_q      <= 1'b0;
		end else begin
			sleep_sync <= {sleep_sync[0], sleep_req};
			idle_sync  <= {idle_sync[0], idle_req};
			cmp_sync   <= {cmp_sync[0], comparator_two_out};
			cmp_q      <= cmp_sync[1];
		end
	end

	// Control registers; reset clears everything
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			control_high_reg <= charge_time_pkg::RESET_BYTE; // RL16
			control_low_reg  <= charge_time_pkg::RESET_BYTE; // RL16
			current_reg      <= charge_time_pkg::RESET_BYTE; // RL16
			irq_en           <= '0;
		end else if (wr) begin
			case (paddr)
				charge_time_pkg::ADDR_CTRL_HIGH:
					control_high_reg <= pwdata[7:0] & charge_time_pkg::CTRL_HIGH_MASK;
				charge_time_pkg::ADDR_CTRL_LOW: control_low_reg <= pwdata[7:0];
				charge_time_pkg::ADDR_CURRENT: current_reg <= pwdata[7:0];
				charge_time_pkg::ADDR_IRQ_EN: irq_en <= pwdata[charge_time_pkg::IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// Delay generation: charge until comparator trips, then pulse until next edge-one clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gen_state        <= charge_time_pkg::GEN_IDLE;
			pulse_output_pin <= 1'b0;
		end else begin
			case (gen_state)
				charge_time_pkg::GEN_IDLE: begin
					pulse_output_pin <= 1'b0;
					if (enabled && delay_mode && edge_one && !halted) // RL5 RL6
						gen_state <= charge_time_pkg::GEN_CHARGE;
				end
				charge_time_pkg::GEN_CHARGE: begin
					if (halted || !enabled || !delay_mode || !edge_one) begin
						gen_state <= charge_time_pkg::GEN_IDLE; // RL10
					end else if (cmp_rise) begin
						gen_state        <= charge_time_pkg::GEN_PULSE; // RL6
						pulse_output_pin <= 1'b1; // RL8
					end
				end
				charge_time_pkg::GEN_PULSE: begin
					if (!edge_one || !enabled || !delay_mode) begin
						gen_state        <= charge_time_pkg::GEN_IDLE;
						pulse_output_pin <= 1'b0;
					end
				end
				default: gen_state <= charge_time_pkg::GEN_IDLE;
			endcase
		end
	end

	// Analog controls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			source_connect  <= 1'b0;
			source_ground   <= 1'b0;
			current_setting <= charge_time_pkg::RESET_BYTE;
			adc_trigger     <= 1'b0;
		end else begin
			// Pulse state stops charging so the capacitor holds at trip point
			source_connect <= next_connect && gen_state != charge_time_pkg::GEN_PULSE; // RL2 RL9
			source_ground  <= enabled && control_high_reg[charge_time_pkg::SOURCE_GROUND_BIT]; // RL15
			current_setting <= current_reg;
			adc_trigger <= enabled && control_high_reg[charge_time_pkg::TRIGGER_BIT]
				&& source_connect && !next_connect;
		end
	end

	assign next_events = {abort_event, cmp_rise && gen_state == charge_time_pkg::GEN_CHARGE};

	// Sticky events; set wins over clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat       <= '0;
			result_invalid <= 1'b0;
			irq            <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~((wr && paddr == charge_time_pkg::ADDR_IRQ_CLR)
				? pwdata[charge_time_pkg::IRQ_WIDTH-1:0] : '0)) | next_events;
			if (abort_event)
				result_invalid <= 1'b1; // RL10
			else if (next_connect)
				result_invalid <= 1'b0;
			irq <= |(((irq_stat | next_events)) & irq_en);
		end
	end

	// APB slave, zero wait states
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata  <= charge_time_pkg::READ_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= charge_time_pkg::READ_ZERO;
			if (psel && !penable) begin
				case (paddr)
					charge_time_pkg::ADDR_CTRL_HIGH: prdata[7:0] <= control_high_reg;
					charge_time_pkg::ADDR_CTRL_LOW: prdata[7:0] <= control_low_reg;
					charge_time_pkg::ADDR_CURRENT: prdata[7:0] <= current_reg;
					charge_time_pkg::ADDR_IRQ_STAT: prdata[charge_time_pkg::IRQ_WIDTH-1:0] <= irq_stat;
					charge_time_pkg::ADDR_IRQ_EN: prdata[charge_time_pkg::IRQ_WIDTH-1:0] <= irq_en;
					charge_time_pkg::ADDR_IRQ_CLR: ;
					charge_time_pkg::ADDR_STATUS:
						prdata[3:0] <= {result_invalid, pulse_output_pin, source_connect, halted};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Low power: a halt must take the source off one edge after it is seen
	a_sleep_kills_source: assert property ( // RL9
		@(posedge clk) disable iff (!rstn)
		sleep_sync[1] |=> !source_connect)
		else $error("source on during sleep");
	a_halt_no_start: assert property ( // RL9
		@(posedge clk) disable iff (!rstn)
		halted && gen_state == charge_time_pkg::GEN_IDLE |=> gen_state == charge_time_pkg::GEN_IDLE)
		else $error("delay started while halted");
	a_idle_stop_source: assert property ( // RL12
		@(posedge clk) disable iff (!rstn)
		idle_sync[1] && control_high_reg[charge_time_pkg::IDLE_STOP_BIT] |=> !source_connect)
		else $error("source on in idle with stop set");
	a_idle_blocks_start: assert property ( // RL12
		@(posedge clk) disable iff (!rstn)
		idle_sync[1] && control_high_reg[charge_time_pkg::IDLE_STOP_BIT]
		&& gen_state == charge_time_pkg::GEN_IDLE |=> gen_state == charge_time_pkg::GEN_IDLE)
		else $error("delay started in stopped idle");
	a_idle_keeps_running: assert property ( // RL11
		@(posedge clk) disable iff (!rstn)
		!sleep_sync[1] && !control_high_reg[charge_time_pkg::IDLE_STOP_BIT] && next_connect
		&& gen_state != charge_time_pkg::GEN_PULSE |=> source_connect)
		else $error("source off though allowed");
	a_abort_flag: assert property ( // RL10
		@(posedge clk) disable iff (!rstn)
		abort_event |=> result_invalid && irq_stat[charge_time_pkg::IRQ_ABORTED])
		else $error("abort not flagged");
	a_invalid_sticky: assert property ( // RL10
		@(posedge clk) disable iff (!rstn)
		result_invalid && !next_connect |=> result_invalid)
		else $error("invalid flag lost");

	// Charging follows the edge status bits, enable and range; grounding follows enable and the ground bit
	a_charge_edges: assert property ( // RL2
		@(posedge clk) disable iff (!rstn)
		source_connect |-> $past(edge_one && !edge_two))
		else $error("charge without edge one");
	a_edge_one_stops: assert property ( // RL2
		@(posedge clk) disable iff (!rstn)
		!edge_one |=> !source_connect)
		else $error("charge without edge one set");
	a_range_off_idle: assert property ( // RL2
		@(posedge clk) disable iff (!rstn)
		source_off |=> !source_connect)
		else $error("charge with range off");
	a_trigger_at_stop: assert property ( // RL2
		@(posedge clk) disable iff (!rstn)
		adc_trigger |-> $past(source_connect) && !source_connect)
		else $error("trigger not at end of charge");
	a_edge_two_stops: assert property ( // RL4
		@(posedge clk) disable iff (!rstn)
		edge_two |=> !source_connect)
		else $error("edge two did not stop charge");
	a_enable_needed: assert property ( // RL14
		@(posedge clk) disable iff (!rstn)
		!enabled |=> !source_connect && !source_ground)
		else $error("disabled unit active");
	a_ground_bit: assert property ( // RL15
		@(posedge clk) disable iff (!rstn)
		enabled && control_high_reg[charge_time_pkg::SOURCE_GROUND_BIT] |=> source_ground)
		else $error("ground bit ignored");
	a_ground_off: assert property ( // RL15
		@(posedge clk) disable iff (!rstn)
		!control_high_reg[charge_time_pkg::SOURCE_GROUND_BIT] |=> !source_ground)
		else $error("ground without ground bit");

	// Delay generation: pulse only from a trip in the charge state
	a_pulse_needs_mode: assert property ( // RL5
		@(posedge clk) disable iff (!rstn)
		$rose(pulse_output_pin) |-> $past(delay_mode && cmp_rise))
		else $error("pulse without trip");
	a_mode_gates_pulse: assert property ( // RL5
		@(posedge clk) disable iff (!rstn)
		!delay_mode |=> !pulse_output_pin)
		else $error("pulse with delay mode off");
	a_idle_no_pulse: assert property ( // RL5
		@(posedge clk) disable iff (!rstn)
		gen_state == charge_time_pkg::GEN_IDLE |=> !pulse_output_pin)
		else $error("pulse from idle state");
	a_disabled_no_pulse: assert property ( // RL14
		@(posedge clk) disable iff (!rstn)
		!enabled |=> !pulse_output_pin)
		else $error("pulse while disabled");
	a_trip_pulse: assert property ( // RL6
		@(posedge clk) disable iff (!rstn)
		gen_state == charge_time_pkg::GEN_CHARGE && cmp_rise && !halted && enabled && delay_mode
		&& edge_one |=> pulse_output_pin)
		else $error("no pulse on trip");
	a_trip_needs_charge: assert property ( // RL6
		@(posedge clk) disable iff (!rstn)
		$rose(pulse_output_pin) |-> $past(gen_state == charge_time_pkg::GEN_CHARGE))
		else $error("pulse outside charge state");
	a_trip_flag: assert property ( // RL6
		@(posedge clk) disable iff (!rstn)
		gen_state == charge_time_pkg::GEN_CHARGE && cmp_rise
		|=> irq_stat[charge_time_pkg::IRQ_PULSE_DONE])
		else $error("trip not flagged");
	a_pulse_stops_charge: assert property ( // RL8
		@(posedge clk) disable iff (!rstn)
		gen_state == charge_time_pkg::GEN_PULSE |=> !source_connect)
		else $error("charging during pulse");
	a_pulse_holds: assert property ( // RL8
		@(posedge clk) disable iff (!rstn)
		gen_state == charge_time_pkg::GEN_PULSE && edge_one && enabled && delay_mode
		|=> pulse_output_pin)
		else $error("pulse ended early");

	// Main scenarios
	c_charge: cover property (@(posedge clk) disable iff (!rstn) $rose(source_connect));
	c_pulse: cover property (@(posedge clk) disable iff (!rstn) $rose(pulse_output_pin));
	c_abort: cover property (@(posedge clk) disable iff (!rstn) abort_event);
	c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
	c_trigger: cover property (@(posedge clk) disable iff (!rstn) adc_trigger);
endmodule

// ---- bench/pulse_cap_model.sv ----
// Pulse capacitor and comparator two as seen from the unit
module pulse_cap_model (
	input  wire logic       clk,
	input  wire logic       source_connect,
	input  wire logic       source_ground,
	input  wire logic [7:0] limit,
	output logic            comparator_two_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] charge = 8'h00;
	always @(posedge clk) begin
		if (source_ground) charge <= 8'h00;
		else if (source_connect && charge != 8'hFF) charge <= charge + 8'h01;
	end
	// Trip time follows charge cycles, so a large limit gives a slow answer
	assign comparator_two_out = charge >= limit;
endmodule

// ---- bench/charge_time_unit_test.sv ----
// Self-checking bench of the charge-time unit
module charge_time_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic sleep_req = 1'b0, idle_req = 1'b0, pready, pslverr, comp, src_on, src_gnd, pin, irq, trig;
	logic [7:0] paddr = 8'h00, cur, limit = 8'h03, lf = 8'h09;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [32:0] exp_q[$];
	int failures = 0, n_tests = 0, cycles = 0, trig_cnt = 0, k;
	always #10 clk = ~clk;
	charge_time_unit u_charge_time_unit (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .idle_req(idle_req),
		.comparator_two_out(comp), .source_connect(src_on), .source_ground(src_gnd),
		.current_setting(cur), .pulse_output_pin(pin), .adc_trigger(trig), .irq(irq));
	pulse_cap_model u_pulse_cap_model (.clk(clk), .source_connect(src_on),
		.source_ground(src_gnd), .limit(limit), .comparator_two_out(comp));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		if (!w) exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, {1'b0, e});
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
	end
	always @(posedge clk) begin
		cycles++;
		if (trig === 1'b1) trig_cnt++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h40);
		rd(charge_time_pkg::ADDR_CTRL_HIGH, 32'h0);
		xfer(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
		$display("reset and map test done");
		lf = lfsr(lf);
		wr(charge_time_pkg::ADDR_CURRENT, {24'h0, lf[7:2], 2'h1});
		@(posedge clk);
		check({25'h0, cur}, {25'h0, lf[7:2], 2'h1});
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h80);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h01);
		rd(charge_time_pkg::ADDR_STATUS, 32'h02);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h03);
		rd(charge_time_pkg::ADDR_STATUS, 32'h00);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h01);
		check({32'h0, pin}, 33'h0);
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h00);
		rd(charge_time_pkg::ADDR_STATUS, 32'h00);
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h82);
		repeat (2) @(posedge clk);
		check({32'h0, src_gnd}, 33'h1);
		$display("charge test done");
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h80);
		wr(charge_time_pkg::ADDR_IRQ_EN, 32'h02);
		sleep_req <= 1'b1;
		repeat (4) @(posedge clk);
		rd(charge_time_pkg::ADDR_STATUS, 32'h09);
		rd(charge_time_pkg::ADDR_IRQ_STAT, 32'h02);
		check({32'h0, irq}, 33'h1);
		wr(charge_time_pkg::ADDR_IRQ_EN, 32'h00);
		repeat (2) @(posedge clk);
		check({32'h0, irq}, 33'h0);
		wr(charge_time_pkg::ADDR_IRQ_CLR, 32'h02);
		rd(charge_time_pkg::ADDR_IRQ_STAT, 32'h00);
		sleep_req <= 1'b0;
		repeat (4) @(posedge clk);
		rd(charge_time_pkg::ADDR_STATUS, 32'h02);
		$display("sleep test done");
		idle_req <= 1'b1;
		repeat (4) @(posedge clk);
		rd(charge_time_pkg::ADDR_STATUS, 32'h02);
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'hA0);
		repeat (4) @(posedge clk);
		rd(charge_time_pkg::ADDR_STATUS, 32'h09);
		rd(charge_time_pkg::ADDR_IRQ_STAT, 32'h02);
		wr(charge_time_pkg::ADDR_IRQ_CLR, 32'h02);
		idle_req <= 1'b0;
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h00);
		$display("idle test done");
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h81);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h01);
		repeat (8) @(posedge clk);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h00);
		repeat (2) @(posedge clk);
		check({1'b0, trig_cnt}, 33'h1);
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h82);
		$display("conversion trigger test done");
		limit <= 8'h14;
		wr(charge_time_pkg::ADDR_CTRL_HIGH, 32'h90);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h01);
		k = 0;
		while (pin !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		check({32'h0, k >= 20 && k < 100}, 33'h1);
		rd(charge_time_pkg::ADDR_STATUS, 32'h04);
		rd(charge_time_pkg::ADDR_IRQ_STAT, 32'h01);
		wr(charge_time_pkg::ADDR_CTRL_LOW, 32'h00);
		rd(charge_time_pkg::ADDR_STATUS, 32'h00);
		$display("delay test done");
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule
